// ==== verilog/seif_pkg.sv ====
// Constants, encodings and small decode helpers for the serial EEPROM front end.
// Assumes a 20 MHz system clock and a host that drives select, clock and data pins.
package seif_pkg;

    // ****************************************
    // Opcodes and extensions
    // ****************************************
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] EXT_LOCK = 2'h0;
    localparam logic [1:0] EXT_FILL = 2'h1;
    localparam logic [1:0] EXT_CLEAR = 2'h2;
    localparam logic [1:0] EXT_UNLOCK = 2'h3;

    // ****************************************
    // Commands handed to the array side
    // ****************************************
    localparam logic [1:0] CMD_ERASE = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_CLEAR_ALL = 2'h2;
    localparam logic [1:0] CMD_FILL_ALL = 2'h3;

    // ****************************************
    // Capacities and widths
    // ****************************************
    localparam logic [1:0] CAP_SMALL = 2'h0;
    localparam logic [1:0] CAP_MID = 2'h1;
    localparam logic [1:0] CAP_LARGE = 2'h2;
    localparam logic [4:0] AW_BASE = 5'h06;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 16;
    localparam int SR_W = 27;
    localparam int CMD_W = 29;
    localparam int CMD_KIND_POS = 27;
    localparam int CMD_ADDR_POS = 16;
    localparam int FIFO_DEPTH = 8;

    // ****************************************
    // Pin slots, reset values, timing
    // ****************************************
    localparam int PIN_SEL = 0;
    localparam int PIN_SCK = 1;
    localparam int PIN_SDI = 2;
    localparam int PIN_ORG = 3;
    localparam logic [3:0] PIN_RST = 4'h0;
    localparam logic SDO_RST = 1'b0;
    localparam int CLK_PERIOD_NS = 50;
    localparam int DESELECT_GAP_NS = 1000;
    localparam int DESELECT_GAP_CYC = (DESELECT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCK_MIN_PERIOD_NS = 1000;
    localparam int SCK_MIN_PERIOD_CYC = (SCK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_WAIT = 3'h1,
        ST_ADDR = 3'h2,
        ST_DATA = 3'h3,
        ST_READ = 3'h4,
        ST_HOLD = 3'h5
    } seif_state_t;

    // Address bits after the opcode
    function automatic logic [4:0] seif_aw(input logic [1:0] cap, input logic org);
        return AW_BASE + {2'h0, cap, 1'b0} + {4'h0, ~org};
    endfunction

    function automatic logic [4:0] seif_dw(input logic org);
        return org ? 5'h10 : 5'h08;
    endfunction

    function automatic logic [10:0] seif_amask(input logic [4:0] aw);
        logic [11:0] one;
        one = 12'h001 << aw;
        return 11'(one - 12'h001);
    endfunction

endpackage

// ==== verilog/seif_fifo.sv ====
// Command FIFO between the serial decoder and the array sequencer.
// Assumes both sides run on the same clock.
`timescale 1ns/10ps
module seif_fifo #(
    parameter int W = 29,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wp_ff;
    logic [PW-1:0] rp_ff;
    logic [CW-1:0] cnt_ff;

    wire do_wr = in_valid & in_ready;
    wire do_rd = out_valid & out_ready;
    wire [PW-1:0] nxt_wp = (wp_ff == PW'(DEPTH - 1)) ? '0 : wp_ff + PW'(1);
    wire [PW-1:0] nxt_rp = (rp_ff == PW'(DEPTH - 1)) ? '0 : rp_ff + PW'(1);
    wire [CW-1:0] nxt_cnt = cnt_ff + CW'(do_wr) - CW'(do_rd);

    assign in_ready = cnt_ff != CW'(DEPTH);
    assign out_valid = cnt_ff != '0;
    assign out_data = mem_ff[rp_ff];

    always_ff @(posedge clk)
    begin
        if (do_wr)
        begin
            mem_ff[wp_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            wp_ff <= do_wr ? nxt_wp : wp_ff;
            rp_ff <= do_rd ? nxt_rp : rp_ff;
            cnt_ff <= nxt_cnt;
        end
    end

endmodule // seif_fifo

// ==== verilog/seif_top.sv ====
// Serial instruction front end of a three-wire EEPROM: pin sampling, framing,
// decode, read streaming and hand-off of programming commands to the array.
// Assumes the array answers a read request within a few system clocks.
`timescale 1ns/10ps
module seif_top #(
    parameter logic [1:0] CAP = 2'h2
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cs_pin,
    input wire logic sck_pin,
    input wire logic sdi_pin,
    input wire logic org_pin,
    output logic sdo_pin,
    output logic sdo_oe,
    output logic rd_req,
    output logic [10:0] rd_addr,
    input wire logic [15:0] rd_data,
    input wire logic rd_ack,
    output logic cmd_valid,
    input wire logic cmd_ready,
    output logic [1:0] cmd_kind,
    output logic [10:0] cmd_addr,
    output logic [15:0] cmd_data
);

    // ****************************************
    // Pin sampling
    // ****************************************
    logic [3:0] s1_ff;
    logic [3:0] s2_ff;
    logic [3:0] s3_ff;
    logic [3:0] pin_ff;
    logic [3:0] pin_d_ff;

    wire [3:0] raw_pins = {org_pin, sdi_pin, sck_pin, cs_pin};
    wire [3:0] agree = ~(s2_ff ^ s3_ff);
    wire [3:0] nxt_pin = (agree & s3_ff) | (~agree & pin_ff);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1_ff <= seif_pkg::PIN_RST;
            s2_ff <= seif_pkg::PIN_RST;
            s3_ff <= seif_pkg::PIN_RST;
            pin_ff <= seif_pkg::PIN_RST;
            pin_d_ff <= seif_pkg::PIN_RST;
        end
        else
        begin
            s1_ff <= raw_pins;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            pin_ff <= nxt_pin;
            pin_d_ff <= pin_ff;
        end
    end

    wire sel = pin_ff[seif_pkg::PIN_SEL];
    wire sel_rise = sel & ~pin_d_ff[seif_pkg::PIN_SEL];
    wire sel_fall = ~sel & pin_d_ff[seif_pkg::PIN_SEL];
    wire sck_rise = pin_ff[seif_pkg::PIN_SCK] & ~pin_d_ff[seif_pkg::PIN_SCK];
    wire sdi = pin_ff[seif_pkg::PIN_SDI];

    // ****************************************
    // Decode
    // ****************************************
    seif_pkg::seif_state_t state_ff;
    seif_pkg::seif_state_t nxt_state;
    logic [4:0] cnt_ff;
    logic [seif_pkg::SR_W-1:0] sr_ff;
    logic org_ff;
    logic unlock_ff;
    logic armed_ff;
    logic push_ff;
    logic status_ff;
    logic [1:0] kind_ff;
    logic [10:0] caddr_ff;
    logic [15:0] cdata_ff;
    logic fifo_in_ready;

    wire [4:0] aw = seif_pkg::seif_aw(CAP, org_ff);
    wire [4:0] dw = seif_pkg::seif_dw(org_ff);
    wire [10:0] amask = seif_pkg::seif_amask(aw);
    wire [seif_pkg::SR_W-1:0] nxt_sr = {sr_ff[seif_pkg::SR_W-2:0], sdi};
    wire shifting = (state_ff == seif_pkg::ST_ADDR) | (state_ff == seif_pkg::ST_DATA);
    wire last_addr = sel & sck_rise & (state_ff == seif_pkg::ST_ADDR) & (cnt_ff == aw + 5'h01);
    wire last_data = sel & sck_rise & (state_ff == seif_pkg::ST_DATA) & (cnt_ff == aw + dw + 5'h01);
    wire [1:0] op = nxt_sr[aw + 5'h01 -: 2];
    wire [1:0] ext = nxt_sr[aw - 5'h01 -: 2];
    wire op_ext = op == seif_pkg::OP_EXT;
    wire is_read = op == seif_pkg::OP_READ;
    wire is_unlock = op_ext & (ext == seif_pkg::EXT_UNLOCK);
    wire is_lock = op_ext & (ext == seif_pkg::EXT_LOCK);
    wire has_data = (op == seif_pkg::OP_WRITE) | (op_ext & (ext == seif_pkg::EXT_FILL));
    wire is_erase = (op == seif_pkg::OP_ERASE) | (op_ext & (ext == seif_pkg::EXT_CLEAR));
    wire [1:0] dec_kind = (op == seif_pkg::OP_WRITE) ? seif_pkg::CMD_WRITE :
                          (op == seif_pkg::OP_ERASE) ? seif_pkg::CMD_ERASE :
                          (ext == seif_pkg::EXT_FILL) ? seif_pkg::CMD_FILL_ALL : seif_pkg::CMD_CLEAR_ALL;
    wire arm_wr = (kind_ff == seif_pkg::CMD_WRITE) | (kind_ff == seif_pkg::CMD_FILL_ALL);
    wire wr_cancel = sel & sck_rise & (state_ff == seif_pkg::ST_HOLD) & arm_wr;
    // A full buffer counts as a running programming cycle to the host
    wire busy = ~fifo_in_ready | push_ff;
    wire start_bit = sel & sck_rise & sdi & ~busy;

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            seif_pkg::ST_IDLE:
                nxt_state = sel_rise ? seif_pkg::ST_WAIT : seif_pkg::ST_IDLE;
            seif_pkg::ST_WAIT:
                nxt_state = start_bit ? seif_pkg::ST_ADDR : seif_pkg::ST_WAIT;
            seif_pkg::ST_ADDR:
                if (last_addr)
                begin
                    nxt_state = is_read ? seif_pkg::ST_READ :
                                has_data ? seif_pkg::ST_DATA : seif_pkg::ST_HOLD;
                end
            seif_pkg::ST_DATA:
                nxt_state = last_data ? seif_pkg::ST_HOLD : seif_pkg::ST_DATA;
            seif_pkg::ST_READ:
                nxt_state = seif_pkg::ST_READ;
            seif_pkg::ST_HOLD:
                nxt_state = seif_pkg::ST_HOLD;
            default:
                nxt_state = seif_pkg::ST_IDLE;
        endcase
        if (!sel)
        begin
            nxt_state = seif_pkg::ST_IDLE;
        end
    end

    // No timeout anywhere: a stalled serial clock simply holds every field
    wire [4:0] nxt_cnt = (state_ff == seif_pkg::ST_WAIT) ? 5'h00 : cnt_ff + {4'h0, shifting & sck_rise};
    wire nxt_unlock = (last_addr & is_unlock) | (unlock_ff & ~(last_addr & is_lock));
    wire arm_set = unlock_ff & ((last_addr & is_erase) | last_data);
    wire nxt_armed = sel & ~wr_cancel & (arm_set | armed_ff);
    wire nxt_push = armed_ff & sel_fall & fifo_in_ready;
    wire stay_wait = (state_ff == seif_pkg::ST_WAIT) & (nxt_state == seif_pkg::ST_WAIT);
    wire nxt_status = ((state_ff == seif_pkg::ST_IDLE) & sel_rise) ? busy : (stay_wait & status_ff);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_ff <= seif_pkg::ST_IDLE;
            cnt_ff <= 5'h00;
            sr_ff <= '0;
            org_ff <= 1'b0;
            unlock_ff <= 1'b0;
            armed_ff <= 1'b0;
            push_ff <= 1'b0;
            status_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            sr_ff <= (shifting & sck_rise) ? nxt_sr : sr_ff;
            org_ff <= start_bit & (state_ff == seif_pkg::ST_WAIT) ? pin_ff[seif_pkg::PIN_ORG] : org_ff;
            unlock_ff <= nxt_unlock;
            armed_ff <= nxt_armed;
            push_ff <= nxt_push;
            status_ff <= nxt_status;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            kind_ff <= seif_pkg::CMD_ERASE;
            caddr_ff <= 11'h000;
            cdata_ff <= 16'h0000;
        end
        else
        begin
            kind_ff <= last_addr ? dec_kind : kind_ff;
            caddr_ff <= last_addr ? nxt_sr[10:0] & amask : caddr_ff;
            cdata_ff <= last_data ? nxt_sr[15:0] & (org_ff ? 16'hFFFF : 16'h00FF) : cdata_ff;
        end
    end

    // ****************************************
    // Read streaming
    // ****************************************
    logic [10:0] raddr_ff;
    logic rd_req_ff;
    logic [15:0] osr_ff;
    logic [3:0] ocnt_ff;
    logic sdo_ff;
    logic oe_ff;

    wire in_read = state_ff == seif_pkg::ST_READ;
    wire out_step = sel & sck_rise & in_read;
    wire word_end = out_step & ({1'b0, ocnt_ff} == dw - 5'h01);
    wire start_rd = last_addr & is_read;
    wire [15:0] rd_aligned = org_ff ? rd_data : {rd_data[7:0], 8'h00};
    wire [10:0] nxt_raddr = start_rd ? (nxt_sr[10:0] & amask) :
                            word_end ? ((raddr_ff + 11'h001) & amask) : raddr_ff;
    wire [15:0] nxt_osr = rd_ack ? rd_aligned : out_step ? {osr_ff[14:0], 1'b0} : osr_ff;
    wire [3:0] nxt_ocnt = (start_rd | word_end) ? 4'h0 : ocnt_ff + {3'h0, out_step};
    // Dummy zero only before the first word; later words run back to back
    wire nxt_sdo = (nxt_status & (nxt_state == seif_pkg::ST_WAIT)) ? ~busy :
                   start_rd ? 1'b0 : out_step ? osr_ff[15] : sdo_ff;
    wire nxt_oe = (nxt_state == seif_pkg::ST_READ) | (nxt_status & (nxt_state == seif_pkg::ST_WAIT));

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            raddr_ff <= 11'h000;
            rd_req_ff <= 1'b0;
            osr_ff <= 16'h0000;
            ocnt_ff <= 4'h0;
            sdo_ff <= seif_pkg::SDO_RST;
            oe_ff <= 1'b0;
        end
        else
        begin
            raddr_ff <= nxt_raddr;
            rd_req_ff <= start_rd | word_end;
            osr_ff <= nxt_osr;
            ocnt_ff <= nxt_ocnt;
            sdo_ff <= nxt_sdo;
            oe_ff <= nxt_oe;
        end
    end

    assign sdo_pin = sdo_ff;
    assign sdo_oe = oe_ff;
    assign rd_req = rd_req_ff;
    assign rd_addr = raddr_ff;

    // ****************************************
    // Command buffer
    // ****************************************
    wire [seif_pkg::CMD_W-1:0] cmd_word;

    seif_fifo #(
        .W(seif_pkg::CMD_W),
        .DEPTH(seif_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(push_ff),
        .in_ready(fifo_in_ready),
        .in_data({kind_ff, caddr_ff, cdata_ff}),
        .out_valid(cmd_valid),
        .out_ready(cmd_ready),
        .out_data(cmd_word)
    );

    assign cmd_kind = cmd_word[seif_pkg::CMD_KIND_POS +: 2];
    assign cmd_addr = cmd_word[seif_pkg::CMD_ADDR_POS +: seif_pkg::ADDR_W];
    assign cmd_data = cmd_word[0 +: seif_pkg::DATA_W];

    // ****************************************
    // Checks
    // ****************************************
    logic [7:0] gap_ff;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gap_ff <= 8'h00;
        end
        else
        begin
            gap_ff <= sel ? 8'h00 : (gap_ff == 8'hFF ? gap_ff : gap_ff + 8'h01);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    start_wait_a: assert property ((state_ff == seif_pkg::ST_WAIT) && sck_rise && !sdi |=> state_ff != seif_pkg::ST_ADDR)
        else $error("Instruction began without a start bit");
    opcode_cnt_a: assert property ((state_ff == seif_pkg::ST_WAIT) && (nxt_state == seif_pkg::ST_ADDR) |=> (cnt_ff == 5'h00) && (state_ff == seif_pkg::ST_ADDR) && $stable(sr_ff))
        else $error("Bit count not cleared at start bit");
    addr_width_a: assert property ((state_ff == seif_pkg::ST_ADDR) && sel && sck_rise && (cnt_ff == aw + 5'h01) |=> state_ff inside {seif_pkg::ST_READ, seif_pkg::ST_DATA, seif_pkg::ST_HOLD})
        else $error("Address field did not end at its width");
    deselect_abort_a: assert property (!sel && (state_ff != seif_pkg::ST_IDLE) |=> (state_ff == seif_pkg::ST_IDLE) && !armed_ff)
        else $error("Deselect did not abandon the instruction");
    read_dummy_a: assert property (start_rd |=> !sdo_ff && oe_ff && rd_req_ff)
        else $error("Read did not start with a dummy zero");
    busy_low_a: assert property ((state_ff == seif_pkg::ST_WAIT) && status_ff && busy && sel |=> !sdo_ff && oe_ff)
        else $error("Busy status not shown as low");
    busy_ignore_a: assert property ((state_ff == seif_pkg::ST_WAIT) && busy |=> state_ff != seif_pkg::ST_ADDR)
        else $error("Bus data accepted while busy");
    unlock_set_a: assert property (last_addr && is_unlock |=> unlock_ff)
        else $error("Unlock instruction not applied");
    clear_arm_a: assert property (last_addr && op_ext && (ext == seif_pkg::EXT_CLEAR) && unlock_ff |=> armed_ff && (kind_ff == seif_pkg::CMD_CLEAR_ALL))
        else $error("Extended clear not decoded");
    static_hold_a: assert property ((state_ff == seif_pkg::ST_ADDR) && sel && !sck_rise |=> $stable(cnt_ff) && $stable(sr_ff) && (state_ff == seif_pkg::ST_ADDR))
        else $error("Partial instruction changed without a clock");
    write_cancel_a: assert property (wr_cancel |=> !armed_ff ##1 !push_ff)
        else $error("Late clock did not cancel the write");

    read_stream_c: cover property (word_end ##[1:400] word_end);
    push_c: cover property (push_ff);
    ready_c: cover property ((state_ff == seif_pkg::ST_WAIT) && status_ff && !busy);
    full_c: cover property (!fifo_in_ready);
    gap_c: cover property (sel_rise && (gap_ff >= 8'(seif_pkg::DESELECT_GAP_CYC)));

endmodule // seif_top

// ==== verif/seif_host_model.sv ====
// Host side of the serial link: drives select, serial clock and data in, samples data out.
// Assumes the bench clock paces every pin change, one step after its rising edge.
`timescale 1ns/10ps
module seif_host_model (
    input wire logic clk,
    input wire logic sdo_pin,
    output logic cs_pin,
    output logic sck_pin,
    output logic sdi_pin
);
    logic [31:0] rx;

    initial
    begin
        cs_pin = 1'b0;
        sck_pin = 1'b0;
        sdi_pin = 1'b1;
        rx = 32'h0;
    end

    // ****************************************
    // Pin tasks
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic sel();
        sck_pin = 1'b0;
        tick(1);
        cs_pin = 1'b1;
        tick(4);
    endtask

    // A released data line flips, so a stale bit can never pass for a driven one
    task automatic desel();
        cs_pin = 1'b0;
        sdi_pin = ~sdi_pin;
        tick(24);
    endtask

    // Half period of 4 clocks; the serial clock stands still between calls
    task automatic bits(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            sdi_pin = v[i];
            tick(4);
            rx = {rx[30:0], sdo_pin};
            sck_pin = 1'b1;
            tick(4);
            sck_pin = 1'b0;
        end
    endtask
endmodule // seif_host_model

// ==== verif/tb_seif_top.sv ====
// Self-checking bench for the serial EEPROM front end, large capacity band.
// Assumes the host model on the link and acts itself as the array side.
`timescale 1ns/10ps
module tb_seif_top;
    logic clk, sys_rst, org_pin, cs_pin, sck_pin, sdi_pin, sdo_pin, sdo_oe;
    logic rd_req, rd_ack, cmd_valid, cmd_ready;
    logic [10:0] rd_addr, cmd_addr;
    logic [15:0] rd_data, cmd_data;
    logic [1:0] cmd_kind;
    int fails, n_tests;

    seif_host_model host (.clk(clk), .sdo_pin(sdo_pin), .cs_pin(cs_pin), .sck_pin(sck_pin), .sdi_pin(sdi_pin));
    seif_top #(.CAP(seif_pkg::CAP_LARGE)) uut (.clk(clk), .sys_rst(sys_rst), .cs_pin(cs_pin), .sck_pin(sck_pin),
        .sdi_pin(sdi_pin), .org_pin(org_pin), .sdo_pin(sdo_pin), .sdo_oe(sdo_oe), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_ack(rd_ack), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_data(cmd_data));

    // ****************************************
    // Array side and helpers
    // ****************************************
    // Word content is derived from its address so each location is distinct
    function automatic logic [15:0] word_of(input logic [10:0] a);
        return {~a[4:0], a};
    endfunction

    always @(posedge clk)
    begin
        rd_ack <= rd_req;
        rd_data <= word_of(rd_addr);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic take_cmd(input logic [1:0] k, input logic [10:0] a, input logic [15:0] d, input bit cd);
        int w;
        w = 0;
        while (cmd_valid !== 1'b1 && w < 100)
        begin
            host.tick(1);
            w++;
        end
        chk(cmd_valid, 32'h1);
        chk(cmd_kind, k);
        chk(cmd_addr, a);
        if (cd)
            chk(cmd_data, d);
        cmd_ready = 1'b1;
        host.tick(1);
        cmd_ready = 1'b0;
        // Lets an edge pass so a following call never raises ready in the same step
        host.tick(1);
    endtask

    task automatic send(input logic [31:0] v, input int n);
        host.sel();
        host.bits(v, n);
        host.desel();
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_write();
        host.sel();
        host.bits(32'h0, 3);
        host.bits({19'h0, 1'b1, seif_pkg::OP_EXT, seif_pkg::EXT_UNLOCK, 8'h00}, 13);
        host.desel();
        host.sel();
        host.bits({19'h0, 1'b1, seif_pkg::OP_WRITE, 10'h155}, 13);
        host.tick(300);
        host.bits(32'h0000A5C3, 16);
        host.desel();
        take_cmd(seif_pkg::CMD_WRITE, 11'h155, 16'hA5C3, 1);
    endtask

    task automatic t_read();
        host.sel();
        host.bits({19'h0, 1'b1, seif_pkg::OP_READ, 10'h3FF}, 13);
        host.bits(32'h0, 17);
        chk(host.rx[16:0], {1'b0, word_of(11'h3FF)});
        chk(sdo_oe, 32'h1);
        host.bits(32'h0, 16);
        chk(host.rx[15:0], word_of(11'h000));
        host.desel();
        chk(sdo_oe, 32'h0);
    endtask

    task automatic t_kinds();
        org_pin = 1'b0;
        send({18'h0, 1'b1, seif_pkg::OP_ERASE, 11'h7AB}, 14);
        take_cmd(seif_pkg::CMD_ERASE, 11'h7AB, 16'h0, 0);
        org_pin = 1'b1;
        send({19'h0, 1'b1, seif_pkg::OP_EXT, seif_pkg::EXT_CLEAR, 8'h00}, 13);
        take_cmd(seif_pkg::CMD_CLEAR_ALL, 11'h200, 16'h0, 0);
        send({3'h0, 1'b1, seif_pkg::OP_EXT, seif_pkg::EXT_FILL, 8'h00, 16'h1234}, 29);
        take_cmd(seif_pkg::CMD_FILL_ALL, 11'h100, 16'h1234, 1);
    endtask

    task automatic t_refuse();
        host.sel();
        host.bits({3'h0, 1'b1, seif_pkg::OP_WRITE, 10'h011, 16'hFFFF}, 29);
        host.bits(32'h0, 1);
        host.desel();
        chk(cmd_valid, 32'h0);
        send({24'h0, 1'b1, seif_pkg::OP_WRITE, 5'h1F}, 8);
        chk(cmd_valid, 32'h0);
    endtask

    // Fill the command queue, then a reselect must see busy and have its bits ignored
    task automatic t_busy();
        for (int i = 0; i < seif_pkg::FIFO_DEPTH; i++)
            send({19'h0, 1'b1, seif_pkg::OP_ERASE, 10'(i)}, 13);
        host.sel();
        host.tick(10);
        chk(sdo_pin, 32'h0);
        host.bits(32'h7, 3);
        take_cmd(seif_pkg::CMD_ERASE, 11'h0, 16'h0, 0);
        host.tick(10);
        chk(sdo_pin, 32'h1);
        host.desel();
        for (int i = 1; i < seif_pkg::FIFO_DEPTH; i++)
            take_cmd(seif_pkg::CMD_ERASE, 11'(i), 16'h0, 0);
        chk(cmd_valid, 32'h0);
    endtask

    task automatic t_lock();
        send({19'h0, 1'b1, seif_pkg::OP_EXT, seif_pkg::EXT_LOCK, 8'h00}, 13);
        send({19'h0, 1'b1, seif_pkg::OP_ERASE, 10'h001}, 13);
        chk(cmd_valid, 32'h0);
    endtask

    // A reset in mid-run must drop the unlock, so a later erase queues nothing
    task automatic t_reset();
        send({19'h0, 1'b1, seif_pkg::OP_EXT, seif_pkg::EXT_UNLOCK, 8'h00}, 13);
        sys_rst = 1'b1;
        host.tick(2);
        sys_rst = 1'b0;
        chk(sdo_oe, 32'h0);
        host.tick(5);
        send({19'h0, 1'b1, seif_pkg::OP_ERASE, 10'h002}, 13);
        chk(cmd_valid, 32'h0);
    endtask

    // ****************************************
    // Run control
    // ****************************************
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial
    begin
        fails = 0;
        n_tests = 0;
        sys_rst = 1'b1;
        org_pin = 1'b1;
        cmd_ready = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        host.tick(5);
        t_write();
        t_read();
        t_kinds();
        t_refuse();
        t_busy();
        t_lock();
        t_reset();
        complete_run();
    end

    // Whole run is near 3700 clocks; the 60000-clock limit, some sixteen times that, means a hang
    initial
    begin
        #3000000;
        fails++;
        complete_run();
    end
endmodule // tb_seif_top
